// >>> logic/pin_sync.sv
// Two-stage synchroniser for a level that arrives from outside the clock.
// Assumes the caller reads only sync_o; the first stage stays internal.
`timescale 1ns/100ps
`default_nettype none

module pin_sync (
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  input  wire logic ce_i,
  input  wire logic async_i,
  output logic      sync_o
);

  logic meta_q;

  // ----------------------------------------------------------------
  // Synchroniser stages
  // ----------------------------------------------------------------
  // The first stage feeds the second stage and nothing else.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_q <= 1'b0;
      sync_o <= 1'b0;
    end else if (ce_i) begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule // pin_sync

`default_nettype wire

// >>> logic/ssf_pkg.sv
// Package for the serial adapter status flag block.
// Holds status bit positions, reset values and the underflow fill code.
// Assumes every user refers to items as ssf_pkg::name.
`default_nettype none

package ssf_pkg;

  // ----------------------------------------------------------------
  // Status register layout
  // ----------------------------------------------------------------
  localparam int unsigned STAT_WIDTH         = 8;
  localparam int unsigned STAT_LOW_WIDTH     = 4;
  localparam int unsigned STAT_RDA_BIT       = 0;
  localparam int unsigned STAT_TDRA_BIT      = 1;
  localparam int unsigned STAT_CARRIER_BIT   = 2;
  localparam int unsigned STAT_CTS_BIT       = 3;
  localparam int unsigned STAT_UNDERFLOW_BIT = 4;
  localparam int unsigned STAT_OVERRUN_BIT   = 5;
  localparam int unsigned STAT_PARITY_BIT    = 6;
  localparam int unsigned STAT_IRQ_BIT       = 7;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [STAT_LOW_WIDTH-1:0] STAT_LOW_RESET = 4'h0;
  localparam logic [STAT_WIDTH-1:0]     FILL_ALL_ONES  = 8'hff;
  localparam logic [STAT_WIDTH-1:0]     FILL_RESET     = 8'hff;

endpackage

`default_nettype wire

// >>> logic/sync_serial_status_flags.sv
// Upper status flags of a synchronous serial adapter: underflow, overrun,
// parity error and interrupt request, plus the underflow pulse pin.
// Assumes the FIFO, transmitter and control logic run on clk_i and deliver
// one-cycle strobes; only the transmit clock pin is asynchronous.
//
// Operation
// - Underflow in sync-fill mode sets bit 4.
// - Underflow clears on clear command or transmitter reset.
// - Underflow flag set sends sync character next.
// - Underflow pin active only in sync-fill mode.
// - Character into full receive FIFO sets bit 5.
// - Overrun clears on status-then-FIFO read or receiver reset.
// - Parity mismatch at FIFO output sets bit 6.
// - Parity error clears on its read or reset.
// - Carrier detect never touches parity or FIFO flags.
// - Bit 7 reads one exactly while interrupt low.
// - Bit 7 gated by receive, transmit, error enables.
// - Underflow pin pulses one transmit clock high phase.
// - Fill is sync code, else all ones.
// - Overrun overwrites the input-end FIFO register.
// - Status read alone changes no flag.
`timescale 1ns/100ps
`default_nettype none

module sync_serial_status_flags (
  input  wire logic                 clk_i,
  input  wire logic                 arst_n_i,
  input  wire logic                 ce_i,
  input  wire logic                 tx_clk_i,
  input  wire logic                 tx_char_req_i,
  input  wire logic                 tx_data_avail_i,
  input  wire logic                 sync_on_underflow_i,
  input  wire logic [7:0]           sync_code_i,
  input  wire logic                 clear_underflow_cmd_i,
  input  wire logic                 tx_soft_reset_i,
  input  wire logic                 rx_soft_reset_i,
  input  wire logic                 rx_char_in_i,
  input  wire logic                 rx_fifo_full_i,
  input  wire logic                 rx_last_load_i,
  input  wire logic                 rx_last_parity_bad_i,
  input  wire logic                 status_rd_i,
  input  wire logic                 rx_fifo_rd_i,
  input  wire logic [3:0]           status_low_i,
  input  wire logic                 rx_int_enable_i,
  input  wire logic                 tx_int_enable_i,
  input  wire logic                 err_int_enable_i,
  output logic      [7:0]           adapter_status_o,
  output logic                      irq_n_o,
  output logic                      tx_underflow_pulse_o,
  output logic                      tx_fill_sel_o,
  output logic      [7:0]           tx_fill_char_o,
  output logic                      rx_overwrite_o
);

  logic       uf_q;
  logic       uf_pend_q;
  logic       pulse_q;
  logic       ovr_q;
  logic       ovr_armed_q;
  logic       par_q;
  logic       irq_q;
  logic [3:0] low_q;
  logic [7:0] fill_q;
  logic       txc_sync;
  logic       txc_d1_q;
  logic       uf_evt;
  logic       ovr_evt;
  logic       par_evt;
  logic       irq_d;

  // ----------------------------------------------------------------
  // Transmit clock pin
  // ----------------------------------------------------------------
  // The transmit clock is only sampled, so it passes two flops first.
  pin_sync u_txc_sync (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .ce_i     (ce_i),
    .async_i  (tx_clk_i),
    .sync_o   (txc_sync)
  );

  // ----------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------
  // Events are qualified by the clock enable so a frozen block sees none.
  assign uf_evt  = ce_i & tx_char_req_i & ~tx_data_avail_i & sync_on_underflow_i;
  assign ovr_evt = ce_i & rx_char_in_i & rx_fifo_full_i;
  assign par_evt = ce_i & rx_last_load_i & rx_last_parity_bad_i;

  // The FIFO overwrites its first stage whenever an overrun happens.
  assign rx_overwrite_o = rx_char_in_i & rx_fifo_full_i;

  // A request while the flag stands, or an underflow now, takes the fill.
  assign tx_fill_sel_o = tx_char_req_i & (uf_q | ~tx_data_avail_i);
  assign tx_fill_char_o = fill_q;

  // ----------------------------------------------------------------
  // Fill character
  // ----------------------------------------------------------------
  // Tracking the mode every cycle keeps the fill ready before a request.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fill_q <= ssf_pkg::FILL_RESET;
    end else if (ce_i) begin
      fill_q <= sync_on_underflow_i ? sync_code_i : ssf_pkg::FILL_ALL_ONES;
    end
  end

  // ----------------------------------------------------------------
  // Transmit underflow flag
  // ----------------------------------------------------------------
  // A new underflow wins over a clear in the same cycle.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      uf_q <= 1'b0;
    end else if (uf_evt) begin
      uf_q <= 1'b1;
    end else if (ce_i && (clear_underflow_cmd_i || tx_soft_reset_i)) begin
      uf_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Underflow pulse pin
  // ----------------------------------------------------------------
  // The pulse waits for the next rising transmit clock and lasts its high
  // phase. It is delayed by the synchroniser, so width is only approximate.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      txc_d1_q  <= 1'b0;
      uf_pend_q <= 1'b0;
      pulse_q   <= 1'b0;
    end else if (ce_i) begin
      txc_d1_q <= txc_sync;
      // A transmitter reset drops a pulse still waiting for its clock, so a
      // later change to all-ones fill never sees a stale pulse on the pin.
      if (uf_evt) begin
        uf_pend_q <= 1'b1;
      end else if (tx_soft_reset_i || (txc_sync && !txc_d1_q)) begin
        uf_pend_q <= 1'b0;
      end
      if (txc_sync && !txc_d1_q) begin
        pulse_q <= uf_pend_q;
      end else if (!txc_sync) begin
        pulse_q <= 1'b0;
      end
    end
  end

  assign tx_underflow_pulse_o = pulse_q;

  // ----------------------------------------------------------------
  // Receive overrun flag
  // ----------------------------------------------------------------
  // A status read while the flag stands arms the clear; the next FIFO read
  // then clears it. A status read on its own changes no flag.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ovr_q       <= 1'b0;
      ovr_armed_q <= 1'b0;
    end else if (ovr_evt) begin
      ovr_q <= 1'b1;
      if (status_rd_i && ovr_q) begin
        ovr_armed_q <= 1'b1;
      end
    end else if (ce_i) begin
      if (rx_soft_reset_i || (rx_fifo_rd_i && ovr_armed_q)) begin
        ovr_q       <= 1'b0;
        ovr_armed_q <= 1'b0;
      end else if (status_rd_i && ovr_q) begin
        ovr_armed_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive parity error flag
  // ----------------------------------------------------------------
  // Follows the character at the FIFO output; carrier detect has no path.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      par_q <= 1'b0;
    end else if (par_evt) begin
      par_q <= 1'b1;
    end else if (ce_i && (rx_fifo_rd_i || rx_soft_reset_i || rx_last_load_i)) begin
      par_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request and status image
  // ----------------------------------------------------------------
  // Receive: data available. Transmit: room or underflow. Error: the
  // carrier, clear-to-send, overrun and parity flags.
  always_comb begin
    irq_d = (rx_int_enable_i  & low_q[ssf_pkg::STAT_RDA_BIT])
          | (tx_int_enable_i  & (low_q[ssf_pkg::STAT_TDRA_BIT] | uf_q))
          | (err_int_enable_i & (low_q[ssf_pkg::STAT_CARRIER_BIT]
                               | low_q[ssf_pkg::STAT_CTS_BIT] | ovr_q | par_q));
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_q <= 1'b0;
      low_q <= ssf_pkg::STAT_LOW_RESET;
    end else if (ce_i) begin
      irq_q <= irq_d;
      low_q <= status_low_i;
    end
  end

  // Bit 7 and the pin come from one flop, so they can never disagree.
  assign irq_n_o = ~irq_q;
  always_comb begin
    adapter_status_o = {irq_q, par_q, ovr_q, uf_q, low_q};
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence seq_uf_event;
    uf_evt;
  endsequence

  sequence seq_ovr_seen_then_read;
    (ce_i && ovr_q && status_rd_i && !ovr_evt)
      ##1 (ce_i && rx_fifo_rd_i && !ovr_evt);
  endsequence

  // Receive data pending with the receive enable held over both flop stages.
  sequence seq_rda_two_cycles;
    (ce_i && rx_int_enable_i && status_low_i[ssf_pkg::STAT_RDA_BIT])
      ##1 (ce_i && rx_int_enable_i);
  endsequence

  uf_set_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    seq_uf_event |=> uf_q && adapter_status_o[ssf_pkg::STAT_UNDERFLOW_BIT])
    else $error("Underflow flag not set after underflow.");

  uf_hold_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    uf_q && !(ce_i && (clear_underflow_cmd_i || tx_soft_reset_i)) |=> uf_q)
    else $error("Underflow flag dropped without a clear.");

  fill_next_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    uf_q && tx_char_req_i |-> tx_fill_sel_o)
    else $error("Character after underflow was not the fill.");

  pin_mode_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    $rose(uf_pend_q) |-> $past(sync_on_underflow_i))
    else $error("Underflow pulse armed outside sync-fill mode.");

  pulse_phase_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    ce_i && uf_pend_q && txc_sync && !txc_d1_q |=> tx_underflow_pulse_o)
    else $error("Underflow pulse missing on transmit clock high.");

  pulse_end_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    ce_i && tx_underflow_pulse_o && !txc_sync |=> !tx_underflow_pulse_o)
    else $error("Underflow pulse outlived the transmit clock high phase.");

  ovr_set_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    ovr_evt |=> ovr_q)
    else $error("Overrun flag not set after overrun.");

  ovr_clear_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    seq_ovr_seen_then_read |=> !ovr_q)
    else $error("Overrun not cleared by status then FIFO read.");

  status_read_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    status_rd_i && !rx_fifo_rd_i && !rx_soft_reset_i && !ovr_evt && !par_evt
      && !rx_last_load_i && !uf_evt && !clear_underflow_cmd_i && !tx_soft_reset_i
      |=> $stable(ovr_q) && $stable(par_q) && $stable(uf_q))
    else $error("Status read changed a flag.");

  par_set_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    par_evt |=> adapter_status_o[ssf_pkg::STAT_PARITY_BIT])
    else $error("Parity error not flagged.");

  par_clear_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    $fell(par_q) |-> $past(rx_fifo_rd_i) || $past(rx_soft_reset_i) || $past(rx_last_load_i))
    else $error("Parity error cleared without a cause.");

  irq_raise_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    seq_rda_two_cycles |=> !irq_n_o && adapter_status_o[ssf_pkg::STAT_IRQ_BIT])
    else $error("Interrupt not raised for pending receive data.");

  irq_gate_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    ce_i && !rx_int_enable_i && !tx_int_enable_i && !err_int_enable_i
      |=> irq_n_o && !adapter_status_o[ssf_pkg::STAT_IRQ_BIT])
    else $error("Interrupt raised with all enables off.");

endmodule // sync_serial_status_flags

`default_nettype wire

// >>> sim/cpu_model.sv
// Processor model: turns one bus access request into the strobe it causes.
// Assumes the bench holds req_i and op_i for one clock, changed on the edge.
`timescale 1ns/100ps
`default_nettype none

module cpu_model (
  input  wire logic       req_i,
  input  wire logic [1:0] op_i,
  output logic            status_rd_o,
  output logic            fifo_rd_o,
  output logic            clr_uf_o
);
  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  // One access per cycle, so a status read and a FIFO read never coincide.
  assign status_rd_o = req_i & (op_i == 2'h0);
  assign fifo_rd_o   = req_i & (op_i == 2'h1);
  assign clr_uf_o    = req_i & (op_i == 2'h2);
endmodule // cpu_model

`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the serial adapter status flag block.
// Assumes the design and the processor model are compiled before it.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic        clk = 1'b0, tx_clk = 1'b0, arst_n = 1'b0, ce = 1'b1, req = 1'b0;
  logic        char_req = 1'b0, avail = 1'b1, mode = 1'b0, tx_rst = 1'b0;
  logic        rx_rst = 1'b0, char_in = 1'b0, full = 1'b0, load = 1'b0, bad = 1'b0;
  logic [1:0]  op = 2'h0;
  logic [2:0]  en = 3'h0;
  logic [7:0]  code = 8'h00, low = 8'h00, fc;
  logic [7:0]  st;
  logic [7:0]  src [3] = '{8'h01, 8'h02, 8'h04};
  logic        irq_n, pulse, sel, ovw, st_rd, f_rd, c_uf;
  logic [7:0]  fill;
  logic [18:0] q [$];
  logic [18:0] nt;
  logic [31:0] seed = 32'h37c17786;
  int          bad_count = 0, comparisons = 0;

  sync_serial_status_flags uut (.clk_i(clk), .arst_n_i(arst_n), .ce_i(ce), .tx_clk_i(tx_clk),
    .tx_char_req_i(char_req), .tx_data_avail_i(avail), .sync_on_underflow_i(mode),
    .sync_code_i(code), .clear_underflow_cmd_i(c_uf), .tx_soft_reset_i(tx_rst),
    .rx_soft_reset_i(rx_rst), .rx_char_in_i(char_in), .rx_fifo_full_i(full),
    .rx_last_load_i(load), .rx_last_parity_bad_i(bad), .status_rd_i(st_rd),
    .rx_fifo_rd_i(f_rd), .status_low_i(low[3:0]), .rx_int_enable_i(en[0]),
    .tx_int_enable_i(en[1]), .err_int_enable_i(en[2]), .adapter_status_o(st),
    .irq_n_o(irq_n), .tx_underflow_pulse_o(pulse), .tx_fill_sel_o(sel),
    .tx_fill_char_o(fill), .rx_overwrite_o(ovw));
  cpu_model cpu (.req_i(req), .op_i(op), .status_rd_o(st_rd), .fifo_rd_o(f_rd), .clr_uf_o(c_uf));

  // ----------------------------------------------------------------
  // Clocks and shared tasks
  // ----------------------------------------------------------------
  // The transmit clock is high for three system cycles, with its edges on falling system clock edges.
  always #20 clk = ~clk;
  always #120 tx_clk = ~tx_clk;

  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    v = v ^ (v << 5);
    return v;
  endfunction

  task automatic cmp(input string nm, input logic [18:0] e, input logic [18:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Note the expected outputs for the current cycle, then let it pass.
  task automatic ex(input logic sl, input logic o, input logic n, input logic [7:0] e);
    q.push_back({fc, sl, o, n, e});
    @(posedge clk);
  endtask

  // Counts pulse-pin cycles over a window longer than one pulse.
  task automatic pulses(input int n);
    int c;
    c = 0;
    repeat (24) @(negedge clk) c += int'(pulse === 1'b1);
    // Resume on a rising edge so the next drive and note keep the usual order.
    @(posedge clk);
    cmp("uf_pulse", 19'(n), 19'(c));
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Oldest note against the settled outputs, away from the launching edge.
  always @(negedge clk) begin
    if (q.size() > 0) begin
      nt = q.pop_front();
      cmp("outputs", nt, {fill, sel, ovw, irq_n, st});
    end
  end

  // A hang ends the run as a mismatch.
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    fc = 8'hff;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    ex(1'b0, 1'b0, 1'b1, 8'h00);
    seed = xs(seed);
    fc = seed[7:0];
    code <= seed[7:0];
    mode <= 1'b1;
    repeat (2) @(posedge clk);
    char_req <= 1'b1;
    avail <= 1'b0;
    ex(1'b1, 1'b0, 1'b1, 8'h00);
    char_req <= 1'b0;
    ex(1'b0, 1'b0, 1'b1, 8'h10);
    pulses(3);
    char_req <= 1'b1;
    avail <= 1'b1;
    ex(1'b1, 1'b0, 1'b1, 8'h10);
    char_req <= 1'b0;
    req <= 1'b1;
    ex(1'b0, 1'b0, 1'b1, 8'h10);
    op <= 2'h2;
    ex(1'b0, 1'b0, 1'b1, 8'h10);
    req <= 1'b0;
    ex(1'b0, 1'b0, 1'b1, 8'h00);
    char_req <= 1'b1;
    avail <= 1'b0;
    ex(1'b1, 1'b0, 1'b1, 8'h00);
    char_req <= 1'b0;
    tx_rst <= 1'b1;
    ex(1'b0, 1'b0, 1'b1, 8'h10);
    tx_rst <= 1'b0;
    ex(1'b0, 1'b0, 1'b1, 8'h00);
    $display("test underflow done");
    mode <= 1'b0;
    repeat (3) @(posedge clk);
    fc = 8'hff;
    char_req <= 1'b1;
    ex(1'b1, 1'b0, 1'b1, 8'h00);
    char_req <= 1'b0;
    ex(1'b0, 1'b0, 1'b1, 8'h00);
    pulses(0);
    avail <= 1'b1;
    full <= 1'b1;
    char_in <= 1'b1;
    ex(1'b0, 1'b1, 1'b1, 8'h00);
    char_in <= 1'b0;
    req <= 1'b1;
    op <= 2'h1;
    ex(1'b0, 1'b0, 1'b1, 8'h20);
    op <= 2'h0;
    ex(1'b0, 1'b0, 1'b1, 8'h20);
    op <= 2'h1;
    ex(1'b0, 1'b0, 1'b1, 8'h20);
    req <= 1'b0;
    ex(1'b0, 1'b0, 1'b1, 8'h00);
    ce <= 1'b0;
    char_in <= 1'b1;
    ex(1'b0, 1'b1, 1'b1, 8'h00);
    ce <= 1'b1;
    load <= 1'b1;
    bad <= 1'b1;
    ex(1'b0, 1'b1, 1'b1, 8'h00);
    char_in <= 1'b0;
    load <= 1'b0;
    rx_rst <= 1'b1;
    ex(1'b0, 1'b0, 1'b1, 8'h60);
    rx_rst <= 1'b0;
    load <= 1'b1;
    ex(1'b0, 1'b0, 1'b1, 8'h00);
    load <= 1'b0;
    req <= 1'b1;
    op <= 2'h0;
    ex(1'b0, 1'b0, 1'b1, 8'h40);
    req <= 1'b0;
    ex(1'b0, 1'b0, 1'b1, 8'h40);
    ex(1'b0, 1'b0, 1'b1, 8'h40);
    req <= 1'b1;
    op <= 2'h1;
    ex(1'b0, 1'b0, 1'b1, 8'h40);
    req <= 1'b0;
    ex(1'b0, 1'b0, 1'b1, 8'h00);
    $display("test receive flags done");
    for (int i = 0; i < 3; i++) begin
      en <= 3'(1 << i);
      low <= 8'h00;
      repeat (3) @(posedge clk);
      low <= src[i];
      ex(1'b0, 1'b0, 1'b1, 8'h00);
      ex(1'b0, 1'b0, 1'b1, src[i]);
      ex(1'b0, 1'b0, 1'b0, src[i] | 8'h80);
      low <= src[(i + 1) % 3];
      ex(1'b0, 1'b0, 1'b0, src[i] | 8'h80);
      ex(1'b0, 1'b0, 1'b0, src[(i + 1) % 3] | 8'h80);
      ex(1'b0, 1'b0, 1'b1, src[(i + 1) % 3]);
    end
    $display("test interrupt done");
    repeat (2) @(posedge clk);
    print_verdict();
  end
endmodule // tb_top

`default_nettype wire
